// [include/pf_pkg.sv]
package pf_pkg;
  localparam logic [7:0] CMD_CHG_CURRENT = 8'h14;
  localparam logic [7:0] CMD_CHG_VOLTAGE = 8'h15;
  localparam logic [15:0] CHG_CURRENT_RESET = 16'h0fa0;
  localparam logic [15:0] CHG_VOLTAGE_RESET = 16'h41a0;
  localparam int FUSE_FAIL_BIT = 15;
  localparam logic [15:0] CAUSE_MASK = 16'h9fff;
  localparam logic [15:0] ENABLE_MASK = 16'h1fff;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] TEMP_STEP = 16'h000a;
  localparam logic [15:0] CELL_STEP = 16'h0019;
  localparam logic [15:0] PACK_STEP = 16'h0064;
  localparam logic [15:0] CURR_STEP = 16'h0064;
  localparam logic [15:0] POWER_STEP = 16'h03e8;
  localparam logic [15:0] AVG_STEP = 16'h000a;
  localparam logic [15:0] MAX_INIT = 16'h0000;
  localparam logic [15:0] MIN_TEMP_INIT = 16'h0578;
  localparam logic [15:0] MIN_PACK_INIT = 16'h4e20;
  localparam logic [15:0] MIN_CELL_INIT = 16'h2710;
  localparam int PERSIST_TIME_S = 60;
  localparam int CLK_HZ = 25000000;
  localparam logic [31:0] PERSIST_CYCLES = 32'(PERSIST_TIME_S * CLK_HZ);

  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] cell_max;
    logic [15:0] cell_min;
    logic [15:0] pack;
    logic [15:0] avg_cur;
    logic [15:0] avg_pow;
  } meas_s;

  typedef struct packed {
    logic [15:0] max_temp;
    logic [15:0] min_temp;
    logic [15:0] avg_temp;
    logic [15:0] max_dsg_cur;
    logic [15:0] max_chg_cur;
    logic [15:0] max_pack;
    logic [15:0] min_pack;
    logic [15:0] max_cell;
    logic [15:0] min_cell;
    logic [15:0] max_dsg_pow;
    logic [15:0] max_chg_pow;
    logic [31:0] temp_samples;
  } life_s;

  typedef struct packed {
    logic [15:0] val;
    logic [31:0] cnt;
  } trk_s;

  typedef struct packed {
    logic [15:0] flags;
    logic [15:0] enables;
    logic safe;
    logic safe_n;
    logic [15:0] chg_cur;
    logic [15:0] chg_vol;
    meas_s meas;
    logic signed [47:0] temp_sum;
    logic [31:0] temp_cnt;
    logic [15:0] avg_temp;
    logic pend;
    logic nv_write;
    life_s nv_rec;
    logic cmd_ack;
    logic cmd_err;
    logic [15:0] cmd_data;
  } state_s;
endpackage

// [verilog/life_track.sv]
`timescale 1ns/10ps
module life_track
  import pf_pkg::*;
#(
  parameter bit IS_MIN = 1'b0,
  parameter bit SIGNED_VAL = 1'b0,
  parameter logic [15:0] STEP = 16'h0001,
  parameter logic [15:0] INIT = 16'h0000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // sample side
  input wire logic enable,
  input wire logic [15:0] sample,
  input wire logic [31:0] persist,
  // record side
  output logic [15:0] value,
  output logic update
);
  trk_s s_q;
  trk_s s_d;
  logic signed [17:0] smp_x;
  logic signed [17:0] val_x;
  logic signed [17:0] diff;
  logic beyond;
  logic jump;

  always_comb begin
    smp_x = SIGNED_VAL ? 18'($signed(sample)) : $signed({2'h0, sample});
    val_x = SIGNED_VAL ? 18'($signed(s_q.val)) : $signed({2'h0, s_q.val});
    diff = IS_MIN ? val_x - smp_x : smp_x - val_x;
    beyond = enable && (diff > 18'sh0);
    jump = diff > $signed({2'h0, STEP});
    update = beyond && (jump || s_q.cnt >= persist);
    s_d = s_q;
    s_d.cnt = beyond ? s_q.cnt + 32'h1 : 32'h0;
    if (update) begin
      s_d.val = sample;
      s_d.cnt = 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= trk_s'{INIT, 32'h0};
    end else begin
      s_q <= s_d;
    end
  end

  assign value = s_q.val;

  chk_timer_restart: assert property (@(posedge clk) disable iff (!rst_n)
    !beyond |=> s_q.cnt == 32'h0)
    else $error("persistence timer not restarted");

  chk_jump_take: assert property (@(posedge clk) disable iff (!rst_n)
    beyond && jump |=> value == $past(sample))
    else $error("record not taken on step excess");
endmodule

// [verilog/pf_lifetime_log.sv]
`timescale 1ns/10ps
module pf_lifetime_log
  import pf_pkg::*;
#(
  parameter logic [31:0] PERSIST = PERSIST_CYCLES
) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic NRST,
  // failure causes
  input wire logic [15:0] CAUSE_SET,
  input wire logic CURRENT_FLOW,
  input wire logic CLEAR_CAUSES,
  input wire logic EN_WR,
  input wire logic [15:0] EN_WDATA,
  // measurements
  input wire logic GAUGING_EN,
  input wire logic MEAS_VALID,
  input wire meas_s MEAS,
  // charge algorithm
  input wire logic CHG_UPDATE,
  input wire logic [15:0] CHG_CURRENT,
  input wire logic [15:0] CHG_VOLTAGE,
  // command read
  input wire logic CMD_RD,
  input wire logic [7:0] CMD_CODE,
  output logic CMD_ACK,
  output logic CMD_ERR,
  output logic [15:0] CMD_DATA,
  // safety outputs
  output logic SAFE_N,
  output logic SAFE,
  output logic [15:0] FAIL_FLAGS,
  output logic [15:0] FAIL_ENABLES,
  // storage write
  output logic NV_WRITE,
  output life_s NV_RECORD
);
  localparam logic [15:0] FUSE_MASK = 16'h8000;

  state_s s_q;
  state_s s_d;
  life_s live;
  logic [9:0] upd;
  logic [15:0] v_max_temp;
  logic [15:0] v_min_temp;
  logic [15:0] v_max_cell;
  logic [15:0] v_min_cell;
  logic [15:0] v_max_pack;
  logic [15:0] v_min_pack;
  logic [15:0] v_max_chg_cur;
  logic [15:0] v_max_dsg_cur;
  logic [15:0] v_max_chg_pow;
  logic [15:0] v_max_dsg_pow;
  logic cur_pos;
  logic cur_neg;
  logic pow_pos;
  logic pow_neg;
  logic [15:0] cur_mag;
  logic [15:0] pow_mag;
  logic [15:0] hit;
  logic act;
  logic [15:0] avg_now;
  logic signed [16:0] avg_diff;
  logic avg_upd;
  logic any_upd;

  // sign split of averaged current and power
  always_comb begin
    cur_pos = GAUGING_EN && !s_q.meas.avg_cur[15] && (s_q.meas.avg_cur != 16'h0);
    cur_neg = GAUGING_EN && s_q.meas.avg_cur[15];
    pow_pos = GAUGING_EN && !s_q.meas.avg_pow[15] && (s_q.meas.avg_pow != 16'h0);
    pow_neg = GAUGING_EN && s_q.meas.avg_pow[15];
    cur_mag = 16'h0 - s_q.meas.avg_cur;
    pow_mag = 16'h0 - s_q.meas.avg_pow;
  end

  // lifetime extremes, all held off until gauging is enabled
  life_track #(
    .IS_MIN(1'b0),
    .SIGNED_VAL(1'b1),
    .STEP(TEMP_STEP),
    .INIT(MAX_INIT)
  ) u_max_temp (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .enable(GAUGING_EN),
    .sample(s_q.meas.temp),
    .persist(PERSIST),
    .value(v_max_temp),
    .update(upd[0])
  );

  life_track #(
    .IS_MIN(1'b1),
    .SIGNED_VAL(1'b1),
    .STEP(TEMP_STEP),
    .INIT(MIN_TEMP_INIT)
  ) u_min_temp (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .enable(GAUGING_EN),
    .sample(s_q.meas.temp),
    .persist(PERSIST),
    .value(v_min_temp),
    .update(upd[1])
  );

  life_track #(
    .IS_MIN(1'b0),
    .SIGNED_VAL(1'b0),
    .STEP(CELL_STEP),
    .INIT(MAX_INIT)
  ) u_max_cell (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .enable(GAUGING_EN),
    .sample(s_q.meas.cell_max),
    .persist(PERSIST),
    .value(v_max_cell),
    .update(upd[2])
  );

  life_track #(
    .IS_MIN(1'b1),
    .SIGNED_VAL(1'b0),
    .STEP(CELL_STEP),
    .INIT(MIN_CELL_INIT)
  ) u_min_cell (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .enable(GAUGING_EN),
    .sample(s_q.meas.cell_min),
    .persist(PERSIST),
    .value(v_min_cell),
    .update(upd[3])
  );

  life_track #(
    .IS_MIN(1'b0),
    .SIGNED_VAL(1'b0),
    .STEP(PACK_STEP),
    .INIT(MAX_INIT)
  ) u_max_pack (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .enable(GAUGING_EN),
    .sample(s_q.meas.pack),
    .persist(PERSIST),
    .value(v_max_pack),
    .update(upd[4])
  );

  life_track #(
    .IS_MIN(1'b1),
    .SIGNED_VAL(1'b0),
    .STEP(PACK_STEP),
    .INIT(MIN_PACK_INIT)
  ) u_min_pack (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .enable(GAUGING_EN),
    .sample(s_q.meas.pack),
    .persist(PERSIST),
    .value(v_min_pack),
    .update(upd[5])
  );

  life_track #(
    .IS_MIN(1'b0),
    .SIGNED_VAL(1'b0),
    .STEP(CURR_STEP),
    .INIT(MAX_INIT)
  ) u_max_chg_cur (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .enable(cur_pos),
    .sample(s_q.meas.avg_cur),
    .persist(PERSIST),
    .value(v_max_chg_cur),
    .update(upd[6])
  );

  life_track #(
    .IS_MIN(1'b0),
    .SIGNED_VAL(1'b0),
    .STEP(CURR_STEP),
    .INIT(MAX_INIT)
  ) u_max_dsg_cur (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .enable(cur_neg),
    .sample(cur_mag),
    .persist(PERSIST),
    .value(v_max_dsg_cur),
    .update(upd[7])
  );

  life_track #(
    .IS_MIN(1'b0),
    .SIGNED_VAL(1'b0),
    .STEP(POWER_STEP),
    .INIT(MAX_INIT)
  ) u_max_chg_pow (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .enable(pow_pos),
    .sample(s_q.meas.avg_pow),
    .persist(PERSIST),
    .value(v_max_chg_pow),
    .update(upd[8])
  );

  life_track #(
    .IS_MIN(1'b0),
    .SIGNED_VAL(1'b0),
    .STEP(POWER_STEP),
    .INIT(MAX_INIT)
  ) u_max_dsg_pow (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .enable(pow_neg),
    .sample(pow_mag),
    .persist(PERSIST),
    .value(v_max_dsg_pow),
    .update(upd[9])
  );

  // running average and live record set
  always_comb begin
    avg_now = 16'h0;
    if (s_q.temp_cnt != 32'h0) begin
      avg_now = 16'(s_q.temp_sum / $signed({16'h0, s_q.temp_cnt}));
    end
    avg_diff = 17'($signed(avg_now)) - 17'($signed(s_q.avg_temp));
    avg_upd = GAUGING_EN && (s_q.temp_cnt != 32'h0)
      && ((avg_diff > $signed({1'b0, AVG_STEP}))
      || (avg_diff < -$signed({1'b0, AVG_STEP})));
    any_upd = (|upd) || avg_upd;
    live.max_temp = v_max_temp;
    live.min_temp = v_min_temp;
    live.avg_temp = s_q.avg_temp;
    live.max_dsg_cur = v_max_dsg_cur;
    live.max_chg_cur = v_max_chg_cur;
    live.max_pack = v_max_pack;
    live.min_pack = v_min_pack;
    live.max_cell = v_max_cell;
    live.min_cell = v_min_cell;
    live.max_dsg_pow = v_max_dsg_pow;
    live.max_chg_pow = v_max_chg_pow;
    live.temp_samples = s_q.temp_cnt;
  end

  // next state
  always_comb begin
    s_d = s_q;
    hit = CAUSE_SET & CAUSE_MASK;
    if (s_q.safe && CURRENT_FLOW) begin
      hit[FUSE_FAIL_BIT] = 1'b1;
    end
    s_d.flags = (CLEAR_CAUSES ? 16'h0 : s_q.flags) | hit;
    act = |(s_d.flags & s_q.enables & ~FUSE_MASK);
    s_d.safe = (s_q.safe && !CLEAR_CAUSES) || act;
    s_d.safe_n = !s_d.safe;
    if (EN_WR) begin
      s_d.enables = EN_WDATA & ENABLE_MASK;
    end
    if (MEAS_VALID) begin
      s_d.meas = MEAS;
      s_d.temp_sum = s_q.temp_sum + 48'($signed(MEAS.temp));
      s_d.temp_cnt = s_q.temp_cnt + 32'h1;
    end
    if (avg_upd) begin
      s_d.avg_temp = avg_now;
    end
    s_d.pend = any_upd;
    s_d.nv_write = s_q.pend;
    if (s_q.pend) begin
      s_d.nv_rec = live;
    end
    if (CHG_UPDATE) begin
      s_d.chg_cur = CHG_CURRENT;
      s_d.chg_vol = CHG_VOLTAGE;
    end
    if (s_d.safe) begin
      s_d.chg_cur = 16'h0;
      s_d.chg_vol = 16'h0;
    end
    s_d.cmd_ack = CMD_RD;
    s_d.cmd_err = 1'b0;
    if (CMD_RD) begin
      case (CMD_CODE)
        CMD_CHG_CURRENT: s_d.cmd_data = s_q.chg_cur;
        CMD_CHG_VOLTAGE: s_d.cmd_data = s_q.chg_vol;
        default: begin
          s_d.cmd_data = 16'h0;
          s_d.cmd_err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      s_q <= '0;
      s_q.enables <= ENABLE_RESET;
      s_q.safe_n <= 1'b1;
      s_q.chg_cur <= CHG_CURRENT_RESET;
      s_q.chg_vol <= CHG_VOLTAGE_RESET;
      s_q.nv_rec.min_temp <= MIN_TEMP_INIT;
      s_q.nv_rec.min_pack <= MIN_PACK_INIT;
      s_q.nv_rec.min_cell <= MIN_CELL_INIT;
    end else begin
      s_q <= s_d;
    end
  end

  assign CMD_ACK = s_q.cmd_ack;
  assign CMD_ERR = s_q.cmd_err;
  assign CMD_DATA = s_q.cmd_data;
  assign SAFE_N = s_q.safe_n;
  assign SAFE = s_q.safe;
  assign FAIL_FLAGS = s_q.flags;
  assign FAIL_ENABLES = s_q.enables;
  assign NV_WRITE = s_q.nv_write;
  assign NV_RECORD = s_q.nv_rec;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);

  chk_cause_latch: assert property (
    CAUSE_SET[0] |=> FAIL_FLAGS[0])
    else $error("cause bit not latched");

  chk_unused_bits: assert property (
    FAIL_FLAGS[14:13] == 2'h0)
    else $error("unused cause bits set");

  chk_fuse_flag: assert property (
    SAFE && CURRENT_FLOW |=> FAIL_FLAGS[FUSE_FAIL_BIT])
    else $error("fuse failure not flagged");

  chk_enable_mask: assert property (
    EN_WR |=> FAIL_ENABLES == ($past(EN_WDATA) & ENABLE_MASK))
    else $error("enable write wrong");

  chk_safe_drive: assert property (
    |(FAIL_FLAGS & FAIL_ENABLES & ~FUSE_MASK) && !CLEAR_CAUSES |=> SAFE && !SAFE_N)
    else $error("safety outputs not driven");

  chk_fuse_excluded: assert property (
    $rose(SAFE) |-> |(FAIL_FLAGS & $past(FAIL_ENABLES) & ~FUSE_MASK))
    else $error("safety asserted without enabled cause");

  chk_safe_hold: assert property (
    SAFE && !CLEAR_CAUSES |=> SAFE && (FAIL_FLAGS & $past(FAIL_FLAGS)) == $past(FAIL_FLAGS))
    else $error("latched safety released");

  chk_gate_gauging_enabled_flag: assert property (
    !GAUGING_EN |-> !any_upd)
    else $error("lifetime update while gauging off");

  chk_full_write: assert property (
    any_upd |-> ##2 NV_WRITE && NV_RECORD == $past(live))
    else $error("lifetime set not written");

  chk_cmd_current: assert property (
    CMD_RD && CMD_CODE == CMD_CHG_CURRENT && !CHG_UPDATE && !SAFE
      |=> CMD_ACK && CMD_DATA == $past(s_q.chg_cur))
    else $error("charge current read wrong");
endmodule

// [verification/host_model.sv]
`timescale 1ns/10ps
module host_model (
  // clock
  input wire logic clk,
  // answer from the device
  input wire logic ack,
  input wire logic err,
  input wire logic [15:0] data,
  // request to the device
  output logic rd,
  output logic [7:0] code
);
  initial begin
    rd = 1'b0;
    code = 8'h00;
  end
  // one read: request for one edge, answer taken 1 ns after that same edge
  task automatic read_cmd(input logic [7:0] c, output logic [15:0] d, output logic e);
    @(posedge clk);
    rd <= 1'b1;
    code <= c;
    @(posedge clk);
    rd <= 1'b0;
    code <= ~c;
    #1;
    d = (ack === 1'b1) ? data : 16'hffff;
    e = (ack === 1'b1) ? err : 1'b1;
  endtask
endmodule

// [verification/test_pf_lifetime_log.sv]
`timescale 1ns/10ps
module test_pf_lifetime_log
  import pf_pkg::*;
();
  localparam logic [31:0] PER = 32'h0000_0014;
  logic clk, nrst, cur_flow, clr, en_wr, gauge_en, meas_vld, chg_upd;
  logic cmd_rd, cmd_ack, cmd_err, safe_n, safe, nv_wr, e;
  logic [15:0] cause_set, en_wdata, chg_cur, chg_vol, cmd_data, flags, enables, d;
  logic [7:0] cmd_code;
  meas_s meas;
  life_s nv_rec;
  int error_cnt, compares;
  bit seen;

  pf_lifetime_log #(.PERSIST(PER)) i_dut (.SYS_CLK(clk), .NRST(nrst), .CAUSE_SET(cause_set),
    .CURRENT_FLOW(cur_flow), .CLEAR_CAUSES(clr), .EN_WR(en_wr), .EN_WDATA(en_wdata),
    .GAUGING_EN(gauge_en), .MEAS_VALID(meas_vld), .MEAS(meas), .CHG_UPDATE(chg_upd),
    .CHG_CURRENT(chg_cur), .CHG_VOLTAGE(chg_vol), .CMD_RD(cmd_rd), .CMD_CODE(cmd_code),
    .CMD_ACK(cmd_ack), .CMD_ERR(cmd_err), .CMD_DATA(cmd_data), .SAFE_N(safe_n),
    .SAFE(safe), .FAIL_FLAGS(flags), .FAIL_ENABLES(enables), .NV_WRITE(nv_wr),
    .NV_RECORD(nv_rec));
  host_model i_host (.clk(clk), .ack(cmd_ack), .err(cmd_err), .data(cmd_data),
    .rd(cmd_rd), .code(cmd_code));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string w);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string w);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %b exp %b", $time, w, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    tick(1);
  endtask
  task automatic set_en(input logic [15:0] v);
    @(posedge clk);
    en_wr <= 1'b1;
    en_wdata <= v;
    @(posedge clk);
    en_wr <= 1'b0;
    tick(1);
  endtask
  task automatic hit(input logic [15:0] v);
    @(posedge clk);
    cause_set <= v;
    @(posedge clk);
    cause_set <= 16'h0000;
    tick(1);
  endtask
  task automatic clear();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    tick(1);
  endtask
  task automatic send(input logic [15:0] t, cu, pw);
    @(posedge clk);
    meas_vld <= 1'b1;
    meas <= '{t, 16'h0fa0, 16'h0bb8, 16'h2ee0, cu, pw};
    @(posedge clk);
    meas_vld <= 1'b0;
  endtask
  task automatic wait_nv(input int lim);
    seen = 1'b0;
    repeat (lim) begin
      @(posedge clk);
      #1;
      if (nv_wr === 1'b1) seen = 1'b1;
    end
  endtask

  task automatic t_reset();
    chk_word(flags, 16'h0000, "flags");
    chk_word(enables, 16'h0000, "enables");
    chk_bit(safe_n, 1'b1, "safe_n");
    chk_word(nv_rec.min_temp, 16'h0578, "min temp init");
    chk_word(nv_rec.min_pack, 16'h4e20, "min pack init");
    chk_word(nv_rec.min_cell, 16'h2710, "min cell init");
    i_host.read_cmd(8'h14, d, e);
    chk_word(d, 16'h0fa0, "current default");
    i_host.read_cmd(8'h15, d, e);
    chk_word(d, 16'h41a0, "voltage default");
    i_host.read_cmd(8'h16, d, e);
    chk_bit(e, 1'b1, "bad code refused");
    chk_word(d, 16'h0000, "bad code data");
    @(posedge clk);
    chg_upd <= 1'b1;
    @(posedge clk);
    chg_upd <= 1'b0;
    i_host.read_cmd(8'h14, d, e);
    chk_word(d, 16'h0bb8, "current update");
    i_host.read_cmd(8'h15, d, e);
    chk_word(d, 16'h3a98, "voltage update");
    $display("test reset done");
  endtask

  task automatic t_causes();
    for (int i = 0; i < 13; i++) begin
      clear();
      set_en(~(16'h0001 << i));
      hit(16'h0001 << i);
      chk_word(flags, 16'h0001 << i, "cause latched");
      chk_bit(safe, 1'b0, "masked cause");
      set_en(16'h0001 << i);
      chk_bit(safe, 1'b1, "safe high");
      chk_bit(safe_n, 1'b0, "safe_n low");
      chk_word(flags, 16'h0001 << i, "cause held");
    end
    i_host.read_cmd(8'h14, d, e);
    chk_word(d, 16'h0000, "current forced off");
    clear();
    chk_bit(safe, 1'b0, "safe cleared");
    set_en(16'hffff);
    chk_word(enables, 16'h1fff, "enable mask");
    hit(16'h6000);
    chk_word(flags, 16'h0000, "unused bits");
    hit(16'h8000);
    chk_word(flags, 16'h8000, "fuse bit only");
    chk_bit(safe, 1'b0, "fuse bit no safe");
    $display("test causes done");
  endtask

  task automatic t_fuse();
    clear();
    hit(16'h0002);
    chk_word(flags, 16'h0002, "no current yet");
    @(posedge clk);
    cur_flow <= 1'b1;
    @(posedge clk);
    cur_flow <= 1'b0;
    tick(1);
    chk_word(flags, 16'h8002, "fuse failure");
    clear();
    chk_word(flags, 16'h0000, "flags cleared");
    chk_bit(safe_n, 1'b1, "safe_n released");
    $display("test fuse done");
  endtask

  task automatic t_life();
    send(16'h00c8, 16'h01f4, 16'h07d0);
    wait_nv(30);
    chk_bit(seen, 1'b0, "gauging off");
    @(posedge clk);
    gauge_en <= 1'b1;
    wait_nv(8);
    chk_bit(seen, 1'b1, "write seen");
    tick(8);
    chk_word(nv_rec.max_temp, 16'h00c8, "max temp");
    chk_word(nv_rec.min_temp, 16'h00c8, "min temp");
    chk_word(nv_rec.max_cell, 16'h0fa0, "max cell");
    chk_word(nv_rec.min_cell, 16'h0bb8, "min cell");
    chk_word(nv_rec.max_pack, 16'h2ee0, "max pack");
    chk_word(nv_rec.min_pack, 16'h2ee0, "min pack");
    chk_word(nv_rec.max_chg_cur, 16'h01f4, "chg cur");
    chk_word(nv_rec.max_chg_pow, 16'h07d0, "chg pow");
    chk_word(nv_rec.avg_temp, 16'h00c8, "avg temp");
    chk_word(nv_rec.temp_samples[15:0], 16'h0001, "temp samples");
    send(16'h00c8, 16'hfda8, 16'hf448);
    tick(12);
    chk_word(nv_rec.max_dsg_cur, 16'h0258, "dsg cur");
    chk_word(nv_rec.max_chg_cur, 16'h01f4, "chg cur kept");
    chk_word(nv_rec.max_dsg_pow, 16'h0bb8, "dsg pow");
    $display("test lifetime done");
  endtask

  task automatic t_persist();
    send(16'h00cd, 16'hfda8, 16'hf448);
    wait_nv(12);
    send(16'h00c8, 16'hfda8, 16'hf448);
    wait_nv(12);
    send(16'h00cd, 16'hfda8, 16'hf448);
    wait_nv(15);
    chk_bit(seen, 1'b0, "timer restarted");
    wait_nv(20);
    chk_bit(seen, 1'b1, "persist write");
    chk_word(nv_rec.max_temp, 16'h00cd, "persist max temp");
    $display("test persist done");
  endtask

  task automatic tally_and_finish();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #400000;
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    nrst = 1'b0;
    cause_set = 16'h0000;
    cur_flow = 1'b0;
    clr = 1'b0;
    en_wr = 1'b0;
    en_wdata = 16'h0000;
    gauge_en = 1'b0;
    meas_vld = 1'b0;
    meas = '0;
    chg_upd = 1'b0;
    chg_cur = 16'h0bb8;
    chg_vol = 16'h3a98;
    error_cnt = 0;
    compares = 0;
    do_reset();
    t_reset();
    t_causes();
    t_fuse();
    t_life();
    t_persist();
    @(posedge clk);
    gauge_en <= 1'b0;
    do_reset();
    t_reset();
    tally_and_finish();
  end
endmodule
